// *** src/pcl_consts.svh ***
`ifndef PCL_CONSTS_SVH
`define PCL_CONSTS_SVH
// System clock period in ns
`define PCL_CLK_NS 4
// Least reconfiguration request low time, ns
`define PCL_TCFG_NS 500
// Longest status low time after a request, us
`define PCL_TSTATUS_US 230
// Least wait from request release to first clock edge, us
`define PCL_TCF2CK_US 230
// Least times round up, longest times round down
`define PCL_TCFG_CYC ((`PCL_TCFG_NS + `PCL_CLK_NS - 1) / `PCL_CLK_NS)
`define PCL_TSTATUS_CYC ((`PCL_TSTATUS_US * 1000) / `PCL_CLK_NS)
`define PCL_TCF2CK_CYC ((`PCL_TCF2CK_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS)
// Default boot word address of the active parallel scheme
`define PCL_BOOT_ADDR 24'h010000
// Compressed stream: escape byte, then a zero-run count
`define PCL_RLE_ESC 8'h00
`define PCL_RUN_MASK 8'h3F
// Data pin enables for each scheme in user mode
`define PCL_OE_SERIAL 8'h01
`define PCL_OE_PARALLEL 8'hFF
`endif

// *** src/pcl_device.sv ***
`default_nettype none
`include "pcl_consts.svh"
module pcl_device
   import pcl_pkg::*;
#(
   parameter int POR_CYCLES    = 1000,
   parameter int TCFG_CYC      = `PCL_TCFG_CYC,
   parameter int TSTATUS_CYC   = `PCL_TSTATUS_CYC,
   parameter int INIT_CYCLES   = 64,
   parameter int LOAD_BYTES    = 16,
   parameter int FIFO_DEPTH    = 8
) (
   input  wire logic           sys_clk,
   input  wire logic           rst,
   pcl_if.device               lnk,
   input  wire logic           parallel_sel,
   input  wire logic           compress_en,
   input  wire logic           serial_user_io_en,
   input  wire logic           dp_user_io_en,
   input  wire pcl_pkg::pcl_byte_t user_dout,
   input  wire logic           boot_addr_wr,
   input  wire logic [23:0]    boot_addr_in,
   output logic      [23:0]    boot_addr,
   output pcl_pkg::pcl_byte_t  cell_data,
   output logic                cell_valid,
   input  wire logic           cell_ready,
   output logic                load_error,
   output logic                user_mode
);
   import pcl_pkg::*;
   generate
      if (POR_CYCLES < 1 || TCFG_CYC < 1 || TSTATUS_CYC < 2 || INIT_CYCLES < 1
          || LOAD_BYTES < 1 || POR_CYCLES >= (1 << 20) || TSTATUS_CYC >= (1 << 20)
          || INIT_CYCLES >= (1 << 20) || LOAD_BYTES >= (1 << 20)) begin : g_chk
         $error("pcl_device: count parameter out of range");
      end
   endgenerate

   pcl_dev_state_e state_q;
   logic [2:0]     clk_s_q;
   pcl_byte_t      d_s0_q;
   pcl_byte_t      d_s1_q;
   logic [1:0]     rq_s_q;
   logic [19:0]    tmr_q;
   logic [19:0]    lowcnt_q;
   logic [19:0]    cnt_q;
   logic [2:0]     bit_cnt_q;
   pcl_byte_t      sh_q;
   logic           esc_q;
   pcl_byte_t      run_q;
   logic           emit_v_q;
   pcl_byte_t      emit_d_q;
   logic           err_q;
   logic           init_q;
   pcl_byte_t      dout_q;
   pcl_byte_t      doe_q;
   logic           rise;
   logic           rq_low;
   logic           req_seen;
   logic           byte_ev;
   pcl_byte_t      byte_val;
   logic           busy;
   logic           f_ready;
   logic           f_push;
   logic           drain;
   logic           flush;

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_s_q <= 3'h0;
         d_s0_q  <= 8'h00;
         d_s1_q  <= 8'h00;
         rq_s_q  <= 2'h3;
      end else begin
         clk_s_q <= {clk_s_q[1:0], lnk.config_clock};
         d_s0_q  <= lnk.data;
         d_s1_q  <= d_s0_q;
         rq_s_q  <= {rq_s_q[0], lnk.reconfig_request_n};
      end
   end

   // Data and clock share the sync delay, so data is aligned to the edge
   assign rise   = clk_s_q[1] && !clk_s_q[2];
   assign rq_low = !rq_s_q[1];

   // Low-time filter fires once per request pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lowcnt_q <= 20'h00000;
      end else if (!rq_low) begin
         lowcnt_q <= 20'h00000;
      end else if (lowcnt_q < 20'(TCFG_CYC)) begin
         lowcnt_q <= lowcnt_q + 20'h00001;
      end
   end
   assign req_seen = rq_low && (lowcnt_q == 20'(TCFG_CYC - 1));
   assign flush    = req_seen && (state_q != PCL_D_POR);

   // Main sequence
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= PCL_D_POR;
         tmr_q   <= 20'h00000;
      end else if (flush) begin
         state_q <= PCL_D_CLEAR;
         tmr_q   <= 20'h00000;
      end else begin
         tmr_q <= tmr_q + 20'h00001;
         unique case (state_q)
            PCL_D_POR: begin
               if (tmr_q == 20'(POR_CYCLES - 1)) begin
                  state_q <= rq_low ? PCL_D_CLEAR : PCL_D_LOAD;
                  tmr_q   <= 20'h00000;
               end
            end
            PCL_D_CLEAR: begin
               // Leave on release, or at the status limit at the latest
               if (!rq_low || tmr_q == 20'(TSTATUS_CYC - 2)) begin
                  state_q <= PCL_D_LOAD;
                  tmr_q   <= 20'h00000;
               end
            end
            PCL_D_LOAD: begin
               tmr_q <= 20'h00000;
               if (cnt_q == 20'(LOAD_BYTES)) state_q <= PCL_D_INIT;
            end
            PCL_D_INIT: begin
               if (tmr_q == 20'(INIT_CYCLES - 1)) state_q <= PCL_D_USER;
            end
            PCL_D_USER: begin
               tmr_q <= 20'h00000;
            end
         endcase
      end
   end

   // Byte assembly; serial bits arrive least significant first
   assign byte_ev  = rise && (state_q == PCL_D_LOAD) && !rq_low && !err_q
                   && (parallel_sel || bit_cnt_q == 3'h7);
   assign byte_val = parallel_sel ? d_s1_q : {d_s1_q[0], sh_q[7:1]};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= 3'h0;
         sh_q      <= 8'h00;
      end else if (flush) begin
         bit_cnt_q <= 3'h0;
      end else if (rise && state_q == PCL_D_LOAD && !rq_low && !parallel_sel) begin
         sh_q      <= {d_s1_q[0], sh_q[7:1]};
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   // Run-length expander; a run is short enough to end before the next
   // serial byte can arrive, so the host is never throttled
   assign busy   = emit_v_q || (run_q != 8'h00);
   assign f_push = busy && f_ready;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         esc_q    <= 1'b0;
         run_q    <= 8'h00;
         emit_v_q <= 1'b0;
         emit_d_q <= 8'h00;
      end else if (flush) begin
         esc_q    <= 1'b0;
         run_q    <= 8'h00;
         emit_v_q <= 1'b0;
      end else begin
         if (f_push && emit_v_q) begin
            emit_v_q <= 1'b0;
         end else if (f_push) begin
            run_q <= run_q - 8'h01;
         end
         if (byte_ev && !busy && !(parallel_sel && compress_en)) begin
            if (compress_en && esc_q) begin
               run_q <= byte_val & `PCL_RUN_MASK;
               esc_q <= 1'b0;
            end else if (compress_en && byte_val == `PCL_RLE_ESC) begin
               esc_q <= 1'b1;
            end else begin
               emit_v_q <= 1'b1;
               emit_d_q <= byte_val;
            end
         end
      end
   end

   // Load failure: compressed parallel data, or a byte while still busy
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_q <= 1'b0;
      end else if (flush) begin
         err_q <= 1'b0;
      end else if (byte_ev && (busy || (parallel_sel && compress_en))) begin
         err_q <= 1'b1;
      end
   end

   pcl_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clr       (flush),
      .in_valid  (busy),
      .in_ready  (f_ready),
      .in_data   (emit_v_q ? emit_d_q : 8'h00),
      .out_valid (cell_valid),
      .out_ready (cell_ready),
      .out_data  (cell_data)
   );
   assign drain = cell_valid && cell_ready;

   // Count of bytes written into the configuration cells
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 20'h00000;
      end else if (flush) begin
         cnt_q <= 20'h00000;
      end else if (drain && cnt_q != 20'(LOAD_BYTES)) begin
         cnt_q <= cnt_q + 20'h00001;
      end
   end

   // Boot address for the active parallel scheme
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         boot_addr <= `PCL_BOOT_ADDR;
      end else if (boot_addr_wr) begin
         boot_addr <= boot_addr_in;
      end
   end

   // User-mode pins; data pins stay released unless the option asks
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         init_q <= 1'b0;
         dout_q <= 8'h00;
         doe_q  <= 8'h00;
      end else begin
         init_q <= (state_q == PCL_D_USER) && !flush;
         dout_q <= user_dout;
         if (state_q != PCL_D_USER || flush) begin
            doe_q <= 8'h00;
         end else if (parallel_sel) begin
            doe_q <= dp_user_io_en ? `PCL_OE_PARALLEL : 8'h00;
         end else begin
            doe_q <= serial_user_io_en ? `PCL_OE_SERIAL : 8'h00;
         end
      end
   end

   // Handshake pins; status and done are open-drain, released means pulled high
   assign lnk.dev_status_oe = (state_q == PCL_D_POR) || (state_q == PCL_D_CLEAR)
                            || err_q;
   assign lnk.dev_done_oe   = (state_q == PCL_D_POR) || (state_q == PCL_D_CLEAR)
                            || (state_q == PCL_D_LOAD);
   assign lnk.init_complete = init_q;
   assign lnk.dev_data      = dout_q;
   assign lnk.dev_data_oe   = doe_q;
   assign load_error        = err_q;
   assign user_mode         = init_q;
endmodule
`default_nettype wire

// *** src/pcl_fifo.sv ***
`default_nettype none
module pcl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             clr,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("pcl_fifo: depth must be a power of two of 2 or more");
      end
   endgenerate
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;
   // Extra pointer bit tells full from empty
   assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = wr_q != rd_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q[AW-1:0]];
   // Storage needs no reset
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   // Pointers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (clr) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** src/pcl_host.sv ***
`default_nettype none
`include "pcl_consts.svh"
module pcl_host
   import pcl_pkg::*;
#(
   parameter int CLK_HALF   = 16,
   parameter int TCFG_CYC   = `PCL_TCFG_CYC,
   parameter int TCF2CK_CYC = `PCL_TCF2CK_CYC,
   parameter int DONE_WAIT  = 256
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   pcl_if.host                     lnk,
   input  wire logic               start,
   input  wire logic               parallel_sel,
   input  wire pcl_pkg::pcl_byte_t src_data,
   input  wire logic               src_valid,
   input  wire logic               src_last,
   output logic                    src_ready,
   output logic                    cfg_done,
   output logic                    cfg_fail,
   output logic                    busy
);
   import pcl_pkg::*;
   generate
      if (CLK_HALF < 4 || TCFG_CYC < 1 || TCF2CK_CYC < 1 || DONE_WAIT < 1
          || TCF2CK_CYC >= (1 << 20) || DONE_WAIT >= (1 << 20)
          || CLK_HALF >= (1 << 20)) begin : g_chk
         $error("pcl_host: count parameter out of range");
      end
   endgenerate

   pcl_host_state_e state_q;
   logic [1:0]      st_s_q;
   logic [1:0]      dn_s_q;
   logic [1:0]      in_s_q;
   logic [19:0]     tmr_q;
   logic [2:0]      bit_q;
   pcl_byte_t       sh_q;
   logic            have_q;
   logic            last_q;
   logic            clk_q;
   logic            rq_n_q;
   logic            fail_q;
   logic            half_end;
   logic            byte_end;
   logic            status_hi;

   // Device pins pass two flip-flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_s_q <= 2'h0;
         dn_s_q <= 2'h0;
         in_s_q <= 2'h0;
      end else begin
         st_s_q <= {st_s_q[0], lnk.config_status_n};
         dn_s_q <= {dn_s_q[0], lnk.load_complete};
         in_s_q <= {in_s_q[0], lnk.init_complete};
      end
   end
   assign status_hi = st_s_q[1];

   assign half_end  = tmr_q == 20'(CLK_HALF - 1);
   assign byte_end  = half_end && clk_q && (parallel_sel || bit_q == 3'h7);
   assign src_ready = (state_q == PCL_H_SEND) && !have_q;

   // Sequence; clock half period sets the rate below the device maximum
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= PCL_H_IDLE;
         tmr_q   <= 20'h00000;
         rq_n_q  <= 1'b1;
         clk_q   <= 1'b0;
         have_q  <= 1'b0;
         last_q  <= 1'b0;
         bit_q   <= 3'h0;
         sh_q    <= 8'h00;
         fail_q  <= 1'b0;
      end else begin
         fail_q <= 1'b0;
         tmr_q  <= tmr_q + 20'h00001;
         unique case (state_q)
            PCL_H_IDLE, PCL_H_DONE: begin
               if (start) begin
                  state_q <= PCL_H_REQ;
                  tmr_q   <= 20'h00000;
               end
            end
            PCL_H_REQ: begin
               rq_n_q <= 1'b0;
               if (tmr_q == 20'(TCFG_CYC)) begin
                  rq_n_q  <= 1'b1;
                  state_q <= PCL_H_WREL;
                  tmr_q   <= 20'h00000;
               end
            end
            PCL_H_WREL: begin
               have_q <= 1'b0;
               bit_q  <= 3'h0;
               if (tmr_q >= 20'(TCF2CK_CYC) && status_hi) begin
                  state_q <= PCL_H_SEND;
                  tmr_q   <= 20'h00000;
               end
            end
            PCL_H_SEND: begin
               if (!status_hi) begin
                  // Device flagged a failed load
                  fail_q  <= 1'b1;
                  clk_q   <= 1'b0;
                  state_q <= PCL_H_REQ;
                  tmr_q   <= 20'h00000;
               end else if (!have_q) begin
                  // No byte yet: hold the clock low as a pause
                  tmr_q <= 20'h00000;
                  if (src_valid) begin
                     sh_q   <= src_data;
                     last_q <= src_last;
                     have_q <= 1'b1;
                  end
               end else if (half_end) begin
                  tmr_q <= 20'h00000;
                  clk_q <= !clk_q;
                  if (clk_q) begin
                     bit_q <= bit_q + 3'h1;
                     if (!parallel_sel) sh_q <= {1'b0, sh_q[7:1]};
                  end
                  if (byte_end) begin
                     have_q <= 1'b0;
                     bit_q  <= 3'h0;
                     if (last_q) state_q <= PCL_H_CHECK;
                  end
               end
            end
            PCL_H_CHECK: begin
               if (dn_s_q[1] && in_s_q[1]) begin
                  state_q <= PCL_H_DONE;
               end else if (tmr_q == 20'(DONE_WAIT)) begin
                  fail_q  <= 1'b1;
                  state_q <= PCL_H_REQ;
                  tmr_q   <= 20'h00000;
               end
            end
         endcase
      end
   end

   // Clock and data stay driven at all times, never left floating
   assign lnk.config_clock       = clk_q;
   assign lnk.host_data          = parallel_sel ? sh_q : {7'h00, sh_q[0]};
   assign lnk.host_data_oe       = 1'b1;
   assign lnk.reconfig_request_n = rq_n_q;
   assign cfg_done               = state_q == PCL_H_DONE;
   assign cfg_fail               = fail_q;
   assign busy                   = (state_q != PCL_H_IDLE) && (state_q != PCL_H_DONE);
endmodule
`default_nettype wire

// *** src/pcl_if.sv ***
`default_nettype none
interface pcl_if;
   import pcl_pkg::*;
   logic      config_clock;
   pcl_byte_t host_data;
   logic      host_data_oe;
   pcl_byte_t dev_data;
   pcl_byte_t dev_data_oe;
   logic      reconfig_request_n;
   logic      dev_status_oe;
   logic      dev_done_oe;
   logic      init_complete;
   // Resolved pin levels; undriven pins float high through pull-ups
   pcl_byte_t data;
   logic      config_status_n;
   logic      load_complete;
   assign data = (host_data & {8{host_data_oe}}) | (dev_data & dev_data_oe)
               | ~({8{host_data_oe}} | dev_data_oe);
   assign config_status_n = ~dev_status_oe;
   assign load_complete   = ~dev_done_oe;
   modport device (input config_clock, data, reconfig_request_n,
                   output dev_data, dev_data_oe, dev_status_oe, dev_done_oe,
                   init_complete);
   modport host (output config_clock, host_data, host_data_oe, reconfig_request_n,
                 input config_status_n, load_complete, init_complete);
endinterface
`default_nettype wire

// *** src/pcl_pkg.sv ***
`default_nettype none
package pcl_pkg;
   typedef logic [7:0] pcl_byte_t;
   typedef enum logic [2:0] {
      PCL_D_POR, PCL_D_CLEAR, PCL_D_LOAD, PCL_D_INIT, PCL_D_USER
   } pcl_dev_state_e;
   typedef enum logic [2:0] {
      PCL_H_IDLE, PCL_H_REQ, PCL_H_WREL, PCL_H_SEND, PCL_H_CHECK, PCL_H_DONE
   } pcl_host_state_e;
endpackage
`default_nettype wire

// *** tb/pcl_properties.sv ***
`default_nettype none
module pcl_properties #(
   parameter int TSTATUS_CYC = 200,
   parameter int TCF2CK_CYC  = 100
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               config_clock,
   input wire pcl_pkg::pcl_byte_t data,
   input wire logic               reconfig_request_n,
   input wire logic               config_status_n,
   input wire logic               load_complete,
   input wire logic               init_complete,
   input wire logic               host_data_oe,
   input wire pcl_pkg::pcl_byte_t dev_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcl_pkg::*;
   int req_cnt;
   int rel_cnt;
   int low_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Length of the request pulse now in progress
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) req_cnt <= 0;
      else req_cnt <= reconfig_request_n ? 0 : req_cnt + 1;
   end
   // Time since release, saturating so it cannot wrap
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) rel_cnt <= 0;
      else if (!reconfig_request_n) rel_cnt <= 0;
      else if (rel_cnt < 1000) rel_cnt <= rel_cnt + 1;
   end
   // Status low while nobody asks for it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) low_cnt <= 0;
      else if (config_status_n || !reconfig_request_n) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end
   // Device parked: both handshake pins pulled low
   sequence s_cleared;
      !config_status_n && !load_complete;
   endsequence
   property p_por_hold;
      $fell(rst) |-> s_cleared [*8];
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("status not low after power-up");
   property p_done_low;
      !config_status_n |-> !load_complete;
   endproperty
   a_done_low: assert property (p_done_low) else $error("load complete high too early");
   property p_status_bound;
      low_cnt <= TSTATUS_CYC + 8;
   endproperty
   a_status_bound: assert property (p_status_bound) else $error("status low too long");
   property p_release_ok;
      $rose(config_status_n) |-> reconfig_request_n && $past(reconfig_request_n);
   endproperty
   a_release_ok: assert property (p_release_ok) else $error("status released early");
   property p_req_width;
      $rose(reconfig_request_n) |-> req_cnt >= 125;
   endproperty
   a_req_width: assert property (p_req_width) else $error("request pulse too short");
   property p_req_clears;
      $rose(reconfig_request_n) |-> ##[0:8] s_cleared;
   endproperty
   a_req_clears: assert property (p_req_clears) else $error("request did not restart");
   property p_first_edge;
      $rose(config_clock) |-> reconfig_request_n && rel_cnt >= TCF2CK_CYC;
   endproperty
   a_first_edge: assert property (p_first_edge) else $error("link clock too soon");
   property p_data_stable;
      $rose(config_clock) |-> $stable(data) ##1 $stable(data) [*3];
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved at clock rise");
   property p_pins_late;
      dev_data_oe != 8'h00 |-> init_complete;
   endproperty
   a_pins_late: assert property (p_pins_late) else $error("data pins driven in load");
   property p_idle_after;
      $rose(init_complete) |-> ##24 (!config_clock && host_data_oe && load_complete);
   endproperty
   a_idle_after: assert property (p_idle_after) else $error("link not parked after load");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcl_pkg::*;
   logic      sys_clk, rst, start, par, cmp, src_valid, src_last, cell_ready, baddr_wr;
   logic      src_ready, cfg_done, cfg_fail, busy, cell_valid, load_error, user_mode;
   logic      clk_d, fail_seen, err_seen, ok, sio_en, pio_en;
   logic [23:0] baddr, boot_addr;
   pcl_byte_t src_data, cell_data, sr, udout;
   pcl_byte_t got[$];
   int        miscompares, checks;
   pcl_if lnk();
   pcl_device #(.POR_CYCLES(50), .TSTATUS_CYC(200), .LOAD_BYTES(4)) i_pcl_device (
      .sys_clk, .rst, .lnk, .parallel_sel(par), .compress_en(cmp), .serial_user_io_en(sio_en),
      .dp_user_io_en(pio_en), .user_dout(udout), .boot_addr_wr(baddr_wr), .boot_addr_in(baddr),
      .boot_addr, .cell_data, .cell_valid, .cell_ready, .load_error, .user_mode);
   // Default link clock half period of 16 keeps the rate under the device maximum
   pcl_host #(.TCF2CK_CYC(100), .DONE_WAIT(300)) i_pcl_host (
      .sys_clk, .rst, .lnk, .start, .parallel_sel(par), .src_data, .src_valid, .src_last,
      .src_ready, .cfg_done, .cfg_fail, .busy);
   // Checker defaults match the shortened status and release times above
   pcl_properties i_pcl_properties (
      .sys_clk, .rst, .config_clock(lnk.config_clock), .data(lnk.data),
      .reconfig_request_n(lnk.reconfig_request_n), .config_status_n(lnk.config_status_n),
      .load_complete(lnk.load_complete), .init_complete(lnk.init_complete),
      .host_data_oe(lnk.host_data_oe), .dev_data_oe(lnk.dev_data_oe));
   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Rebuild the last unit seen on the pins, serial LSB first
   always @(posedge sys_clk) begin
      clk_d <= lnk.config_clock;
      if (lnk.config_clock && !clk_d) sr <= par ? lnk.data : {lnk.data[0], sr[7:1]};
      if (cell_valid && cell_ready) got.push_back(cell_data);
      if (cfg_fail === 1'h1) fail_seen <= 1'h1;
      if (load_error === 1'h1) err_seen <= 1'h1;
   end
   task automatic cmp_val(input string what, input logic [23:0] exp, input logic [23:0] act);
      checks++;
      if (act !== exp) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", what, exp, act);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic act);
      cmp_val(what, {23'h0, exp}, {23'h0, act});
   endtask
   // Bounded wait, since a lost handshake must not hang the run
   task automatic wait_done(output logic seen);
      seen = 1'h0;
      for (int i = 0; i < 6000 && seen !== 1'h1; i++) begin
         @(negedge sys_clk);
         seen = cfg_done;
      end
   endtask
   // One load: start, feed bytes with a long pause after the first
   task automatic run(input logic p, input logic c, input pcl_byte_t s[$], output logic seen);
      @(posedge sys_clk);
      par <= p;
      cmp <= c;
      start <= 1'h1;
      @(posedge sys_clk);
      start <= 1'h0;
      foreach (s[i]) begin
         if (i == 1) src_valid <= 1'h0;
         if (i == 1) repeat (300) @(posedge sys_clk);
         src_data <= s[i];
         src_last <= (i == s.size() - 1);
         src_valid <= 1'h1;
         do @(negedge sys_clk); while (src_ready !== 1'h1);
         @(posedge sys_clk);
      end
      src_valid <= 1'h0;
      wait_done(seen);
   endtask
   task automatic check_cells(input pcl_byte_t e[$]);
      cmp_val("cell count", 24'(e.size()), 24'(got.size()));
      foreach (e[i]) cmp_val("cell", {16'h0, e[i]}, {16'h0, got[i]});
      got.delete();
   endtask
   task automatic check_user(input pcl_byte_t last);
      cmp_bit("done", 1'h1, ok);
      cmp_val("last unit on pins", {16'h0, last}, {16'h0, sr});
      cmp_bit("status", 1'h1, lnk.config_status_n);
      cmp_bit("load complete", 1'h1, lnk.load_complete);
      cmp_bit("user mode", 1'h1, user_mode);
      cmp_bit("load error", 1'h0, load_error);
      cmp_bit("host busy", 1'h0, busy);
   endtask
   // User I/O option hands the data pins to the device only in user mode
   task automatic check_pins(input pcl_byte_t oe);
      @(posedge sys_clk);
      {sio_en, pio_en, udout} <= {2'h3, 8'h5A};
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp_val("data pin enables", {16'h0, oe}, {16'h0, lnk.dev_data_oe});
      cmp_val("user data out", 24'h00005A, {16'h0, lnk.dev_data});
      @(posedge sys_clk);
      {sio_en, pio_en} <= 2'h0;
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      rst = 1'h1;
      {start, par, cmp, src_valid, src_last, baddr_wr, fail_seen, err_seen, sio_en, pio_en} = 10'h000;
      cell_ready = 1'h1;
      src_data = 8'h00;
      udout = 8'h00;
      baddr = 24'h000000;
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      @(negedge sys_clk);
      cmp_bit("status after power-up", 1'h0, lnk.config_status_n);
      cmp_bit("load complete after power-up", 1'h0, lnk.load_complete);
      cmp_val("boot address", 24'h010000, boot_addr);
      @(posedge sys_clk);
      baddr <= 24'h2A4000;
      baddr_wr <= 1'h1;
      @(posedge sys_clk);
      baddr_wr <= 1'h0;
      @(negedge sys_clk);
      cmp_val("boot address", 24'h2A4000, boot_addr);
      run(1'h0, 1'h0, '{8'hA5, 8'h3C, 8'h81, 8'h7E}, ok);
      check_user(8'h7E);
      check_cells('{8'hA5, 8'h3C, 8'h81, 8'h7E});
      check_pins(8'h01);
      run(1'h1, 1'h0, '{8'hC3, 8'h18, 8'hFF, 8'h42}, ok);
      check_user(8'h42);
      check_cells('{8'hC3, 8'h18, 8'hFF, 8'h42});
      run(1'h0, 1'h1, '{8'h5A, 8'h00, 8'h02, 8'hE7}, ok);
      check_user(8'hE7);
      check_cells('{8'h5A, 8'h00, 8'h00, 8'hE7});
      run(1'h1, 1'h1, '{8'h5A, 8'h11, 8'h22, 8'h33}, ok);
      cmp_bit("done with refused stream", 1'h0, ok);
      cmp_bit("failure seen by host", 1'h1, fail_seen);
      cmp_bit("load error seen", 1'h1, err_seen);
      got.delete();
      run(1'h1, 1'h0, '{8'h0F, 8'hF0, 8'h55, 8'hAA}, ok);
      check_user(8'hAA);
      check_cells('{8'h0F, 8'hF0, 8'h55, 8'hAA});
      check_pins(8'hFF);
      end_of_test();
   end
   // Watchdog, well past the longest expected run
   initial begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
